// ### hw/wit_consts.vh
// Constants for the watch and interval timer block.
// Overview of operation
// - Mode bits 6..4 pick interval tap 2^4..2^11 of watch clock; bit 7 picks source.
// - Mode bits 3..2 pick watch period 2^14, 2^13, 2^5 or 2^4 watch clocks.
// - Counter run bit 0 stops and clears the 5-bit counter; 1 lets it count.
// - Enable bit 0 stops watch and interval timing and holds prescaler and 5-bit counter cleared.
// - The 5-bit counter counts only while run and enable bits are both 1.
// - Mode register resets to zero and is readable and writable.
// - Clearing run clears only the 5-bit counter; interval timer keeps running.
// - Derived main-clock count clock reaches the timer only while feed enable is 1.
// - Derived count clock is main clock over 2^(m+1) times N, N zero meaning 256.
// - Watch interrupt repeats at the selected watch period while counting.
// - Interval interrupt repeats each time the selected prescaler tap elapses.
`ifndef WIT_CONSTS_VH
`define WIT_CONSTS_VH
`define WIT_ADR_W 28
`define WIT_ADR_MODE 28'hFFFF680
`define WIT_ADR_PMODE 28'hFFFF684
`define WIT_ADR_PCMP 28'hFFFF688
`define WIT_MODE_RST 8'h00
`define WIT_PMODE_RST 8'h00
`define WIT_PCMP_RST 8'h00
`define WIT_PMODE_MASK 8'h13
`define WIT_BIT_ENABLE 0
`define WIT_BIT_RUN 1
`define WIT_BIT_FLAG_LO 2
`define WIT_BIT_FLAG_HI 3
`define WIT_BIT_TAP_LO 4
`define WIT_BIT_TAP_HI 6
`define WIT_BIT_SRC 7
`define WIT_BIT_FEED 4
`define WIT_BIT_DIV_LO 0
`define WIT_BIT_DIV_HI 1
`define WIT_PRE_W 11
`define WIT_CNT_W 5
`define WIT_TAP_BASE 3
`define WIT_CNT_TAP 8
`define WIT_N_ZERO_VAL 9'h100
`define WIT_CMP_W 9
`endif

// ### hw/wit_top.v
// Watch timer with interval timer behind a classic Wishbone slave.
//
// The Wishbone slave port was chosen for this implementation.
`include "wit_consts.vh"
module wit_top (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`WIT_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire sub_clock_i,
  output reg watch_irq_o,
  output reg interval_irq_o
);
  reg [7:0] watch_mode_control;
  reg [7:0] prescale_mode_reg;
  reg [7:0] prescale_compare_reg;
  reg sub_s1;
  reg sub_s2;
  reg sub_s3;
  reg [2:0] div_cnt;
  reg [`WIT_CMP_W-1:0] cmp_cnt;
  reg [`WIT_PRE_W-1:0] pre;
  reg [`WIT_CNT_W-1:0] cnt;
  reg [2:0] div_mask;
  reg [31:0] next_dat;
  wire watch_run_enable;
  wire counter_run;
  wire flag_time_sel_lo;
  wire flag_time_sel_hi;
  wire [2:0] tap_sel;
  wire clock_source_sel;
  wire main_clock_feed_enable;
  wire [1:0] source_divide_sel;
  wire req;
  wire wr;
  wire sub_tick;
  wire bgcs_tick;
  wire [`WIT_CMP_W-1:0] n_val;
  wire [`WIT_CMP_W-1:0] cmp_lim;
  wire brg_tick;
  wire fw_tick;
  wire [7:0] tap_hit;
  wire cnt_tick;
  wire cnt_wrap;
  wire cnt_half;
  wire watch_hit;

  assign watch_run_enable = watch_mode_control[`WIT_BIT_ENABLE];
  assign counter_run = watch_mode_control[`WIT_BIT_RUN];
  assign flag_time_sel_lo = watch_mode_control[`WIT_BIT_FLAG_LO];
  assign flag_time_sel_hi = watch_mode_control[`WIT_BIT_FLAG_HI];
  assign tap_sel = watch_mode_control[`WIT_BIT_TAP_HI:`WIT_BIT_TAP_LO];
  assign clock_source_sel = watch_mode_control[`WIT_BIT_SRC];
  assign main_clock_feed_enable = prescale_mode_reg[`WIT_BIT_FEED];
  assign source_divide_sel =
    prescale_mode_reg[`WIT_BIT_DIV_HI:`WIT_BIT_DIV_LO];

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];

  // Register file with byte-wide writes on lane 0.
  always @(posedge clk_i) begin
    if (rst_i) begin
      watch_mode_control <= `WIT_MODE_RST;
      prescale_mode_reg <= `WIT_PMODE_RST;
      prescale_compare_reg <= `WIT_PCMP_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= next_dat;
      end
      if (wr && wb_adr_i == `WIT_ADR_MODE) begin
        watch_mode_control <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == `WIT_ADR_PMODE) begin
        prescale_mode_reg <= wb_dat_i[7:0] & `WIT_PMODE_MASK;
      end
      if (wr && wb_adr_i == `WIT_ADR_PCMP) begin
        prescale_compare_reg <= wb_dat_i[7:0];
      end
    end
  end

  // Read mux; unmapped addresses read as zero.
  always @* begin
    next_dat = 32'h00000000;
    case (wb_adr_i)
      `WIT_ADR_MODE: next_dat = {24'h000000, watch_mode_control};
      `WIT_ADR_PMODE: next_dat = {24'h000000, prescale_mode_reg};
      `WIT_ADR_PCMP: next_dat = {24'h000000, prescale_compare_reg};
      default: next_dat = 32'h00000000;
    endcase
  end

  // Subclock pin synchroniser and rising edge detect.
  always @(posedge clk_i) begin
    if (rst_i) begin
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_s3 <= 1'b0;
    end else if (ce_i) begin
      sub_s1 <= sub_clock_i;
      sub_s2 <= sub_s1;
      sub_s3 <= sub_s2;
    end
  end
  assign sub_tick = sub_s2 & ~sub_s3;

  // Source divider: one tick each 2^m main clocks.
  always @* begin
    case (source_divide_sel)
      2'b00: div_mask = 3'h0;
      2'b01: div_mask = 3'h1;
      2'b10: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end
  assign bgcs_tick = main_clock_feed_enable &
    ((div_cnt & div_mask) == div_mask);
  assign n_val = (prescale_compare_reg == 8'h00) ? `WIT_N_ZERO_VAL :
    {1'b0, prescale_compare_reg};
  assign cmp_lim = {n_val[`WIT_CMP_W-2:0], 1'b0} - 9'h001;
  assign brg_tick = bgcs_tick && (cmp_cnt == cmp_lim);

  always @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 3'h0;
      cmp_cnt <= 9'h000;
    end else if (ce_i) begin
      if (!main_clock_feed_enable) begin
        div_cnt <= 3'h0;
        cmp_cnt <= 9'h000;
      end else begin
        div_cnt <= div_cnt + 3'h1;
        if (brg_tick) begin
          cmp_cnt <= 9'h000;
        end else if (bgcs_tick) begin
          cmp_cnt <= cmp_cnt + 9'h001;
        end
      end
    end
  end

  assign fw_tick = clock_source_sel ? brg_tick : sub_tick;

  // Interval taps: tap i elapses when the low i+4 prescaler bits roll over.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_tap
      assign tap_hit[gi] = fw_tick & (&pre[gi+`WIT_TAP_BASE:0]);
    end
  endgenerate

  // The 5-bit counter runs on fw or on fw/2^9.
  assign cnt_tick = flag_time_sel_hi ? fw_tick : tap_hit[`WIT_CNT_TAP-3];
  assign cnt_wrap = cnt_tick & (&cnt);
  assign cnt_half = cnt_tick & (&cnt[`WIT_CNT_W-2:0]);
  assign watch_hit = counter_run &
    (flag_time_sel_lo ? cnt_half : cnt_wrap);

  always @(posedge clk_i) begin
    if (rst_i) begin
      pre <= 11'h000;
      cnt <= 5'h00;
      watch_irq_o <= 1'b0;
      interval_irq_o <= 1'b0;
    end else if (ce_i) begin
      if (!watch_run_enable) begin
        pre <= 11'h000;
        cnt <= 5'h00;
        watch_irq_o <= 1'b0;
        interval_irq_o <= 1'b0;
      end else begin
        if (fw_tick) begin
          pre <= pre + 11'h001;
        end
        if (!counter_run) begin
          cnt <= 5'h00;
        end else if (cnt_tick) begin
          cnt <= cnt + 5'h01;
        end
        watch_irq_o <= watch_hit;
        interval_irq_o <= tap_hit[tap_sel];
      end
    end
  end
endmodule // wit_top

// ### sim/wit_chk.sv
// Checker for the watch and interval timer ports.
`include "wit_consts.vh"
module wit_chk (
  input logic clk_i,
  input logic rst_i,
  input logic ce_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [`WIT_ADR_W-1:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic sub_clock_i,
  input logic watch_irq_o,
  input logic interval_irq_o
);
  logic [7:0] mode;
  logic [2:0] off;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of the mode register and cycles since counting last ran.
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode <= 8'h00;
      off <= 3'h0;
    end else begin
      if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i &&
          wb_sel_i[0] && wb_adr_i == `WIT_ADR_MODE) begin
        mode <= wb_dat_i[7:0];
      end
      off <= (mode[1:0] == 2'h3) ? 3'h0 : (off == 3'h7 ? off : off + 3'h1);
    end
  end
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
    |=> wb_ack_o) else $error("no bus answer");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  mode_read_a: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == `WIT_ADR_MODE |-> wb_dat_o == {24'h0, mode})
    else $error("mode read wrong");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  watch_pulse_a: assert property (watch_irq_o |=> !watch_irq_o)
    else $error("watch pulse long");
  intv_pulse_a: assert property (interval_irq_o |=> !interval_irq_o)
    else $error("interval pulse long");
  watch_stop_a: assert property (off == 3'h7 |-> !watch_irq_o)
    else $error("watch pulse while stopped");
  intv_stop_a: assert property (off == 3'h7 && !mode[0] &&
    !$past(mode[0], 6) |-> !interval_irq_o) else $error("interval while off");
  cover property (watch_irq_o);
  cover property (interval_irq_o);
  cover property (wb_ack_o && wb_we_i);
endmodule // wit_chk
bind wit_top wit_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sub_clock_i(sub_clock_i),
  .watch_irq_o(watch_irq_o), .interval_irq_o(interval_irq_o));

// ### sim/watch_interval_timer_tb.sv
// Self-checking bench for the watch and interval timer.
`include "wit_consts.vh"
module watch_interval_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [27:0] wb_adr_i = 28'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, sub_clock_i = 0, watch_irq_o, interval_irq_o;
  logic [7:0] q, d;
  integer n_mismatch = 0, tests_run = 0, seed = 32'h4177, ph = 0, tick = 0;
  integer cyc_n = 0, wn = 0, in = 0, wt = 0, wd = 0, it = 0, id = 0, ct = 0;
  integer cd = 0, w0, i0, t;
  wit_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sub_clock_i(sub_clock_i),
    .watch_irq_o(watch_irq_o), .interval_irq_o(interval_irq_o));
  initial forever #5 clk_i = ~clk_i;
  // Subclock of four system cycles and a record of pulse spacing.
  always @(posedge clk_i) begin
    ph <= ph + 1;
    sub_clock_i <= ph[1];
    if (ph % 4 == 2) tick <= tick + 1;
    cyc_n <= cyc_n + 1;
    if (watch_irq_o === 1'b1) begin
      wd <= tick - wt; wt <= tick; wn <= wn + 1;
    end
    if (interval_irq_o === 1'b1) begin
      id <= tick - it; it <= tick; cd <= cyc_n - ct; ct <= cyc_n; in <= in + 1;
    end
  end
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      $display("ERROR %0t seen %h expected %h", $time, s, e);
      n_mismatch++;
    end
  endtask
  task bus(input logic w, input logic [27:0] a, input logic [7:0] v);
    integer k;
    @(posedge clk_i);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a;
    wb_dat_i <= {24'h0, v};
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin n_mismatch++; conclude; end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 0; wb_stb_i <= 0;
  endtask
  task run(input logic [7:0] m);
    integer k;
    bus(1, `WIT_ADR_MODE, m & 8'hFC); bus(1, `WIT_ADR_MODE, m);
    w0 = wn; i0 = in; k = 0;
    while ((wn < w0 + 2 || in < i0 + 2) && k < 40000) begin
      @(posedge clk_i); k++;
    end
    if (k >= 40000) begin n_mismatch++; conclude; end
  endtask
  task quiet(input logic [7:0] a, input logic [7:0] v, input integer e);
    bus(1, a == 8'h80 ? `WIT_ADR_MODE : `WIT_ADR_PMODE, v);
    // Let a pulse already in the output flop reach the counters first.
    @(posedge clk_i);
    w0 = wn; i0 = in;
    repeat (300) @(posedge clk_i);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    bus(0, `WIT_ADR_MODE, 8'h00); chk(q, 8'h00);
    d = $random(seed) & 8'hFC;
    bus(1, `WIT_ADR_MODE, d); bus(0, `WIT_ADR_MODE, 8'h00); chk(q, d);
    bus(0, 28'h0000010, 8'h00); chk(q, 8'h00);
    for (t = 0; t < 8; t++) begin
      run({1'b0, t[2:0], 1'b1, t[0], 2'h3});
      chk(id, 1 << (4 + t));
      chk(wd, t[0] ? 16 : 32);
    end
    run(8'h0F);
    quiet(8'h80, 8'h0D, 0);
    chk(wn - w0, 0);
    chk(in - i0 >= 4, 1);
    quiet(8'h80, 8'h00, 0);
    chk(in - i0, 0);
    bus(1, `WIT_ADR_PMODE, 8'h10);
    bus(1, `WIT_ADR_PCMP, 8'h02);
    run(8'h8F);
    chk(cd, 64);
    quiet(8'h00, 8'h00, 0);
    chk(in - i0, 0);
    conclude;
  end
endmodule // watch_interval_timer_tb
